// file: inc/isofa_defs.svh
// Functional notes
// RL1: Firmware enables endpoint, start address, frame interrupt.
// RL2: Frame start presents previous frame data, counts.
// RL3: Firmware drains each FIFO within one frame.
// RL4: Writing one clears the frame start flag.
// RL5: Each OUT endpoint has its byte port.
// RL6: Shared status records CRC error per endpoint.
// RL7: Bad CRC data still delivered to firmware.
// RL8: Sixteen endpoints share one 1024-byte RAM.
// RL9: Start offsets relative, anywhere from zero.
// RL10: Start register bits 7:2 hold A9:A4.
// RL11: Effective start is register times four.
// RL12: Size is next start minus own, times four.
// RL13: Last IN endpoint takes remainder of RAM.
// RL14: Start registers consecutive, OUT8-15 then IN8-15.
// RL15: Firmware writes starts with low bits zero.
// RL16: Device performs no overlap or capacity check.
// RL17: Buffers swap at every frame start.
// RL18: Storage is double buffered, 2048 bytes.
// RL19: Missing frame start made by internal timer.
// RL20: Each port read returns next byte, advances.
`ifndef ISOFA_DEFS_SVH
`define ISOFA_DEFS_SVH
// ----------------------------------------
// Register map of the device (byte index)
// ----------------------------------------
`define ISOFA_REG_START0 8'h00
`define ISOFA_REG_VALID 8'h10
`define ISOFA_REG_CTRL 8'h11
`define ISOFA_REG_CRCERR 8'h12
`define ISOFA_REG_CNT_LO0 8'h20
`define ISOFA_REG_CNT_HI0 8'h28
`define ISOFA_REG_DATA0 8'h30
// ----------------------------------------
// Fields and sizes
// ----------------------------------------
`define ISOFA_CTRL_FLAG_BIT 0
`define ISOFA_CTRL_IEN_BIT 1
`define ISOFA_RAM_BYTES 11'h400
`define ISOFA_NUM_START 16
`define ISOFA_NUM_OUT 8
// ----------------------------------------
// Timing
// ----------------------------------------
`define ISOFA_FRAME_US 1000
`define ISOFA_CLK_MHZ 25
`define ISOFA_FRAME_CYC (`ISOFA_FRAME_US * `ISOFA_CLK_MHZ)
`define ISOFA_SOF_SLACK_CYC 250
// ----------------------------------------
// Controller register map
// ----------------------------------------
`define ISOFA_HREG_CMD 4'h0
`define ISOFA_HREG_ADDR 4'h1
`define ISOFA_HREG_WDATA 4'h2
`define ISOFA_HREG_RDATA 4'h3
`define ISOFA_HREG_STATUS 4'h4
`endif

// file: inc/isofa_pkg.sv
package isofa_pkg;
    typedef logic [7:0] isofa_byte_t;
    typedef logic [9:0] isofa_addr_t;
    typedef enum logic [1:0] {
        ISOFA_IDLE = 2'b00,
        ISOFA_WAIT = 2'b01,
        ISOFA_DONE = 2'b10
    } isofa_hstate_e;
endpackage : isofa_pkg

// file: inc/isofa_if.sv
`timescale 1ns/1ps
interface isofa_if;
    // Firmware register port (one-cycle strobes, read data next cycle)
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    // USB link side
    logic sof;
    logic out_we;
    logic [2:0] out_ep;
    logic [7:0] out_data;
    logic out_crc_err;
    // Interrupt line
    logic irq;
    modport dev (input addr, wdata, wr, rd, sof, out_we, out_ep, out_data, out_crc_err,
                 output rdata, irq);
    modport fw (output addr, wdata, wr, rd, sof, out_we, out_ep, out_data, out_crc_err,
                input rdata, irq);
endinterface : isofa_if

// file: design/isofa_device.sv
`timescale 1ns/1ps
`include "isofa_defs.svh"

module isofa_device #(
    parameter int FRAME_CYC = `ISOFA_FRAME_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Link and firmware carrier
    isofa_if.dev bus,
    // Status
    output logic frame_flag_out,
    output logic [7:0] crc_err_out
);
    import isofa_pkg::*;
    // ----------------------------------------
    // Storage and registers
    // ----------------------------------------
    logic [7:0] ram [0:2047]; // RL18
    logic bank;
    logic [7:0] start_reg [0:15];
    logic [7:0] valid;
    logic flag;
    logic ien;
    logic [7:0] err_live, err_prev;
    logic [9:0] wcnt [0:7];
    logic [9:0] pcnt [0:7];
    logic [9:0] rptr [0:7];
    logic [31:0] timer;
    logic sof_s1, sof_s2, sof_d;
    logic [7:0] rdata;
    logic irq;
    logic sof_evt;
    logic [9:0] base [0:15];
    logic [10:0] size [0:15];

    // ----------------------------------------
    // Allocation arithmetic
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_alloc
            assign base[g] = {start_reg[g], 2'b00}; // RL11 RL10 RL9
            if (g < 15) begin : g_mid
                // No overlap check; a smaller next start wraps silently RL16
                assign size[g] = {1'b0, start_reg[g+1], 2'b00} - {1'b0, start_reg[g], 2'b00}; // RL12
            end else begin : g_last
                assign size[g] = `ISOFA_RAM_BYTES - {1'b0, start_reg[g], 2'b00}; // RL13
            end
        end
    endgenerate

    // ----------------------------------------
    // Frame start: link pulse or timer
    // ----------------------------------------
    // Two flops tame the link level; a third marks its rising edge
    always_ff @(posedge core_clk_in) begin
        sof_s1 <= srst_in ? 1'b0 : bus.sof;
        sof_s2 <= srst_in ? 1'b0 : sof_s1;
        sof_d <= srst_in ? 1'b0 : sof_s2;
    end
    // Any frame start restarts the timer, so it only fires on a gap
    always_ff @(posedge core_clk_in) begin
        if (srst_in || sof_evt) begin
            timer <= '0;
        end else begin
            timer <= timer + 32'h1;
        end
    end
    // Slack lets a slightly late packet win over the timer
    assign sof_evt = (sof_s2 && !sof_d) ||
                     (timer == 32'(FRAME_CYC + `ISOFA_SOF_SLACK_CYC)); // RL19

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            bank <= 1'b0;
        end else if (sof_evt) begin
            bank <= ~bank; // RL17
        end
    end

    // ----------------------------------------
    // Host OUT data into the live bank
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        // Bytes past the region are dropped, never wrapped
        if (bus.out_we && valid[bus.out_ep] && wcnt[bus.out_ep] < size[bus.out_ep][9:0]) begin
            ram[{bank, 10'(base[bus.out_ep] + wcnt[bus.out_ep])}] <= bus.out_data; // RL8
        end
    end
    generate
        for (g = 0; g < 8; g++) begin : g_ep
            logic take;
            assign take = bus.out_we && bus.out_ep == 3'(g) && valid[g] &&
                          wcnt[g] < size[g][9:0];
            always_ff @(posedge core_clk_in) begin
                if (srst_in || sof_evt) begin
                    wcnt[g] <= '0;
                end else if (take) begin
                    wcnt[g] <= wcnt[g] + 10'h1;
                end
            end
            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    err_live[g] <= 1'b0;
                    err_prev[g] <= 1'b0;
                    pcnt[g] <= '0;
                end else if (sof_evt) begin
                    // A byte stored on the swap edge still belongs to the closing frame
                    pcnt[g] <= wcnt[g] + {9'h000, take}; // RL2
                    err_prev[g] <= err_live[g] | (bus.out_we && bus.out_ep == 3'(g) &&
                                                  bus.out_crc_err); // RL6
                    err_live[g] <= 1'b0;
                end else if (bus.out_we && bus.out_ep == 3'(g) && bus.out_crc_err) begin
                    err_live[g] <= 1'b1; // RL7
                end
            end
            always_ff @(posedge core_clk_in) begin
                if (srst_in || sof_evt) begin
                    rptr[g] <= '0;
                end else if (bus.rd && bus.addr == `ISOFA_REG_DATA0 + 8'(g) &&
                             rptr[g] < pcnt[g]) begin
                    rptr[g] <= rptr[g] + 10'h1; // RL20
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Firmware registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < 16; i++) begin
                start_reg[i] <= 8'h00;
            end
            valid <= 8'h00;
            ien <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr < `ISOFA_REG_START0 + 8'h10) begin
                start_reg[bus.addr[3:0]] <= {bus.wdata[7:2], 2'b00}; // RL14 RL15
            end else if (bus.addr == `ISOFA_REG_VALID) begin
                valid <= bus.wdata;
            end else if (bus.addr == `ISOFA_REG_CTRL) begin
                ien <= bus.wdata[`ISOFA_CTRL_IEN_BIT];
            end
        end
    end

    // ----------------------------------------
    // Frame flag and interrupt line
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            flag <= 1'b0;
        end else if (sof_evt) begin
            flag <= 1'b1;
        end else if (bus.wr && bus.addr == `ISOFA_REG_CTRL &&
                     bus.wdata[`ISOFA_CTRL_FLAG_BIT]) begin
            flag <= 1'b0; // RL4
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq <= 1'b0;
        end else begin
            irq <= flag & ien;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            if (bus.addr < 8'h10) begin
                rdata <= start_reg[bus.addr[3:0]];
            end else if (bus.addr == `ISOFA_REG_VALID) begin
                rdata <= valid;
            end else if (bus.addr == `ISOFA_REG_CTRL) begin
                rdata <= {6'h00, ien, flag};
            end else if (bus.addr == `ISOFA_REG_CRCERR) begin
                rdata <= err_prev;
            end else if (bus.addr[7:3] == 5'h04) begin
                rdata <= pcnt[bus.addr[2:0]][7:0];
            end else if (bus.addr[7:3] == 5'h05) begin
                rdata <= {6'h00, pcnt[bus.addr[2:0]][9:8]};
            end else if (bus.addr[7:3] == 5'h06) begin
                // Drained bank is the one the host is not filling RL5
                rdata <= (rptr[bus.addr[2:0]] < pcnt[bus.addr[2:0]]) ?
                         ram[{~bank, 10'(base[bus.addr[2:0]] + rptr[bus.addr[2:0]])}] : 8'h00;
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Output ports
    // ----------------------------------------
    assign bus.rdata = rdata;
    assign bus.irq = irq;
    assign frame_flag_out = flag;
    assign crc_err_out = err_prev;
endmodule : isofa_device

// file: design/isofa_fw.sv
`timescale 1ns/1ps
`include "isofa_defs.svh"

module isofa_fw (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Device carrier
    isofa_if.fw bus,
    // Controller register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic busy_out
);
    import isofa_pkg::*;
    isofa_hstate_e state;
    logic [7:0] dev_addr, dev_wdata, dev_rdata;
    logic d_wr, d_rd;
    logic [7:0] rdata;
    logic busy;
    // ----------------------------------------
    // Command engine: one device access per command
    // ----------------------------------------
    // Firmware sequences of RL1, RL3 and RL4 are issued through these commands
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state <= ISOFA_IDLE;
            busy <= 1'b0;
            d_wr <= 1'b0;
            d_rd <= 1'b0;
            dev_addr <= 8'h00;
            dev_wdata <= 8'h00;
            dev_rdata <= 8'h00;
        end else begin
            d_wr <= 1'b0;
            d_rd <= 1'b0;
            unique case (state)
                ISOFA_IDLE: begin
                    if (wr_in && addr_in == `ISOFA_HREG_ADDR) begin
                        dev_addr <= wdata_in;
                    end
                    if (wr_in && addr_in == `ISOFA_HREG_WDATA) begin
                        dev_wdata <= wdata_in;
                    end
                    if (wr_in && addr_in == `ISOFA_HREG_CMD) begin
                        d_wr <= wdata_in[0];
                        d_rd <= ~wdata_in[0];
                        state <= ISOFA_WAIT;
                        busy <= 1'b1;
                    end
                end
                ISOFA_WAIT: begin
                    state <= ISOFA_DONE;
                end
                ISOFA_DONE: begin
                    dev_rdata <= bus.rdata;
                    state <= ISOFA_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                `ISOFA_HREG_ADDR: rdata <= dev_addr;
                `ISOFA_HREG_WDATA: rdata <= dev_wdata;
                `ISOFA_HREG_RDATA: rdata <= dev_rdata;
                `ISOFA_HREG_STATUS: rdata <= {6'h00, bus.irq, state != ISOFA_IDLE};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
    assign bus.addr = dev_addr;
    assign bus.wdata = dev_wdata;
    assign bus.wr = d_wr;
    assign bus.rd = d_rd;
    // Link stimulus belongs to the bench; held idle here
    assign bus.sof = 1'b0;
    assign bus.out_we = 1'b0;
    assign bus.out_ep = 3'h0;
    assign bus.out_data = 8'h00;
    assign bus.out_crc_err = 1'b0;
    assign rdata_out = rdata;
    assign busy_out = busy;
endmodule : isofa_fw

// file: dv/isofa_asserts.sv
`timescale 1ns/1ps
module isofa_asserts (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Carrier signals
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic frame_flag_out
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic clr;
    assign clr = wr && addr == 8'h11 && wdata[0];
    sequence clear_s;
        clr ##1 !frame_flag_out;
    endsequence
    sequence start_rd_s;
        rd && addr < 8'h10;
    endsequence
    start_low_a: assert property (start_rd_s |=> rdata[1:0] == 2'b00)
        else $error("start register low bits set");
    flag_clear_a: assert property (clr |=> !frame_flag_out)
        else $error("flag not cleared");
    flag_hold_a: assert property (frame_flag_out && !clr |=> frame_flag_out)
        else $error("flag dropped without clear");
    flag_read_a: assert property (rd && addr == 8'h11 |=> rdata[0] == $past(frame_flag_out))
        else $error("flag readback wrong");
    irq_cause_a: assert property (irq |-> $past(frame_flag_out))
        else $error("irq without flag");
    irq_drop_a: assert property (!frame_flag_out |=> !irq)
        else $error("irq stays after clear");
    frame_timer_a: assert property (clear_s |-> ##[1:460] frame_flag_out)
        else $error("no frame from timer");
    unmapped_zero_a: assert property (rd && addr > 8'h12 && addr < 8'h20 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : isofa_asserts

// file: dv/iso_out_fifo_allocation_tb.sv
`timescale 1ns/1ps
module iso_out_fifo_allocation_tb;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out, crc_a, crc_b;
    logic busy_out, flag_a, flag_b;
    int err_total = 0;
    int checks = 0;
    isofa_if bus_a ();
    isofa_if bus_b ();
    isofa_fw u_isofa_fw (.core_clk_in(core_clk_in), .srst_in(srst_in), .bus(bus_a),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .busy_out(busy_out));
    isofa_device #(.FRAME_CYC(200)) u_isofa_device (.core_clk_in(core_clk_in),
        .srst_in(srst_in), .bus(bus_a), .frame_flag_out(flag_a), .crc_err_out(crc_a));
    // Long timer here so only driven frame starts swap during data checks
    isofa_device #(.FRAME_CYC(4000)) u_isofa_device_b (.core_clk_in(core_clk_in),
        .srst_in(srst_in), .bus(bus_b), .frame_flag_out(flag_b), .crc_err_out(crc_b));
    isofa_asserts u_isofa_asserts (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .addr(bus_a.addr), .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd),
        .rdata(bus_a.rdata), .irq(bus_a.irq), .frame_flag_out(flag_a));
    initial begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    // ----
    // Common tasks
    // ----
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic b_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus_b.addr <= a;
        bus_b.wdata <= d;
        bus_b.wr <= 1'b1;
        @(posedge core_clk_in);
        bus_b.wr <= 1'b0;
    endtask : b_wr
    task automatic b_chk(input logic [7:0] a, input logic [9:0] e);
        @(posedge core_clk_in);
        bus_b.addr <= a;
        bus_b.rd <= 1'b1;
        @(posedge core_clk_in);
        bus_b.rd <= 1'b0;
        #1;
        check({2'b00, bus_b.rdata}, e);
    endtask : b_chk
    task automatic host(input logic [2:0] ep, input int n, input logic [7:0] b, input int bad);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            bus_b.out_we <= 1'b1;
            bus_b.out_ep <= ep;
            bus_b.out_data <= b + i[7:0];
            bus_b.out_crc_err <= (i == bad);
        end
        @(posedge core_clk_in);
        bus_b.out_we <= 1'b0;
    endtask : host
    task automatic frame_b();
        @(posedge core_clk_in);
        bus_b.sof <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        bus_b.sof <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        #1;
    endtask : frame_b
    task automatic c_io(input logic [3:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
    endtask : c_io
    task automatic d_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        c_io(4'h1, a, 1'b1);
        c_io(4'h2, d, 1'b1);
        c_io(4'h0, {7'h00, w}, 1'b1);
        repeat (2) @(posedge core_clk_in);
        for (int i = 0; i < 20; i++) begin
            #1;
            if (busy_out === 1'b0) return;
            @(posedge core_clk_in);
        end
        err_total++;
        report_and_stop();
    endtask : d_op
    task automatic f_chk(input logic [7:0] a, input logic [9:0] e);
        d_op(1'b0, a, 8'h00);
        c_io(4'h3, 8'h00, 1'b0);
        check({2'b00, rdata_out}, e);
    endtask : f_chk
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        b_chk(8'h05, 10'h000);
        for (int i = 0; i < 16; i++) b_wr(i[7:0], 8'h4b + i[7:0]);
        for (int i = 0; i < 16; i++) b_chk(i[7:0], {2'b00, (8'h4b + i[7:0]) & 8'hfc});
        b_wr(8'h13, 8'h5a);
        b_chk(8'h13, 10'h000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_frame();
        // Ep8 304 bytes, ep9 16 bytes, ep10 through IN14 empty, IN15 the remaining 704 bytes
        for (int i = 0; i < 16; i++) b_wr(i[7:0], i == 0 ? 8'h00 : (i == 1 ? 8'h4c : 8'h50));
        b_wr(8'h10, 8'hff);
        host(3'd0, 300, 8'h00, 999);
        host(3'd1, 18, 8'h80, 1);
        host(3'd2, 2, 8'h40, 99);
        frame_b();
        check({9'h000, flag_b}, 10'h001);
        check({2'b00, crc_b}, 10'h002);
        b_chk(8'h12, 10'h002);
        b_chk(8'h20, 10'h02c);
        b_chk(8'h28, 10'h001);
        b_chk(8'h21, 10'h010);
        b_chk(8'h22, 10'h000);
        host(3'd0, 4, 8'hf0, 99);
        for (int i = 0; i < 300; i++) b_chk(8'h30, {2'b00, i[7:0]});
        b_chk(8'h30, 10'h000);
        for (int i = 0; i < 16; i++) b_chk(8'h31, {2'b00, 8'h80 + i[7:0]});
        b_wr(8'h11, 8'h01);
        @(posedge core_clk_in);
        #1;
        check({9'h000, flag_b}, 10'h000);
        check({9'h000, bus_b.irq}, 10'h000);
        frame_b();
        b_chk(8'h20, 10'h004);
        b_chk(8'h30, 10'h0f0);
        check({2'b00, crc_b}, 10'h000);
        frame_b();
        b_chk(8'h20, 10'h000);
        $display("test frame done");
    endtask : t_frame
    task automatic t_timer();
        d_op(1'b1, 8'h0f, 8'hff);
        f_chk(8'h0f, 10'h0fc);
        f_chk(8'h13, 10'h000);
        // Enable and clear together so irq waits for the next timer frame start
        d_op(1'b1, 8'h11, 8'h03);
        for (int i = 0; i < 600 && bus_a.irq !== 1'b1; i++) begin
            @(posedge core_clk_in);
            #1;
        end
        check({9'h000, bus_a.irq}, 10'h001);
        if (bus_a.irq !== 1'b1) report_and_stop();
        check({2'b00, crc_a}, 10'h000);
        f_chk(8'h11, 10'h003);
        d_op(1'b1, 8'h11, 8'h03);
        check({9'h000, flag_a}, 10'h000);
        f_chk(8'h11, 10'h002);
        $display("test timer done");
    endtask : t_timer
    initial begin
        bus_b.addr = 8'h00;
        bus_b.wdata = 8'h00;
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        bus_b.sof = 1'b0;
        bus_b.out_we = 1'b0;
        bus_b.out_ep = 3'd0;
        bus_b.out_data = 8'h00;
        bus_b.out_crc_err = 1'b0;
        repeat (12) @(posedge core_clk_in);
        srst_in <= 1'b0;
        t_regs();
        t_frame();
        t_timer();
        report_and_stop();
    end
endmodule : iso_out_fifo_allocation_tb
